// >>> include/dpac_consts.svh
`ifndef DPAC_CONSTS_SVH
`define DPAC_CONSTS_SVH

// register byte offsets
`define DPAC_OFF_CTRL     8'h00
`define DPAC_OFF_RETRY    8'h04
`define DPAC_OFF_PFAIL    8'h08
`define DPAC_OFF_STATUS   8'h0C
`define DPAC_OFF_IRQ_STS  8'h10
`define DPAC_OFF_IRQ_EN   8'h14
`define DPAC_OFF_IRQ_CLR  8'h18

// control register fields
`define DPAC_CTRL_FAN_BIT     0
`define DPAC_CTRL_DIR_LSB     1
`define DPAC_CTRL_STOP_BIT    3
`define DPAC_CTRL_OCL_BIT     4
`define DPAC_CTRL_THM_LSB     5
`define DPAC_CTRL_RESET       32'h0000_0010

// retry register fields: count [3:0], interval in 0.1 s [15:8]
`define DPAC_RETRY_CNT_LSB    0
`define DPAC_RETRY_IVL_LSB    8
`define DPAC_RETRY_RESET      32'h0000_3200
`define DPAC_RETRY_MAX        4'hA
`define DPAC_IVL_MIN          8'h05
`define DPAC_IVL_MAX          8'hC8

// power fail register: fall rate [15:0] in 0.01 Hz/s, time [31:16] in 0.1 s
`define DPAC_PF_RATE_LSB      0
`define DPAC_PF_TIME_LSB      16
`define DPAC_PF_AUTO          16'h03E7
`define DPAC_PF_TIME_MAX      16'h012C
`define DPAC_PF_RATE_MAX      16'h2710
`define DPAC_PFAIL_RESET      32'h03E7_03E7

// timing: 0.1 s tick and 10 minute fan hold at 200 MHz
`define DPAC_CLK_HZ           200000000
`define DPAC_TICK_S_DIV       10
`define DPAC_FAN_HOLD_MIN     10
`define DPAC_FAN_HOLD_TICKS   (`DPAC_FAN_HOLD_MIN * 60 * `DPAC_TICK_S_DIV)

// interrupt bits
`define DPAC_IRQ_TRIP         0
`define DPAC_IRQ_ALARM        1
`define DPAC_IRQ_RETRY        2
`define DPAC_IRQ_THM_WARN     3
`define DPAC_IRQ_W            4

`endif

// >>> include/dpac_pkg.sv
package dpac_pkg;
  typedef enum logic [1:0] {DPAC_DIR_ANY, DPAC_DIR_NO_REV, DPAC_DIR_NO_FWD, DPAC_DIR_RSV} dpac_dir_t;
  typedef enum logic [1:0] {DPAC_THM_OFF, DPAC_THM_TRIP, DPAC_THM_WARN, DPAC_THM_NTC} dpac_thm_t;

  typedef struct packed {
    logic        fan_ctrl_en;
    dpac_dir_t   dir_limit;
    logic        coast_stop;
    logic        ocl_en;
    dpac_thm_t   thm_mode;
    logic [3:0]  retry_cnt;
    logic [7:0]  retry_ivl;
    logic [15:0] pf_rate;
    logic [15:0] pf_time;
  } dpac_cfg_t;

  typedef struct packed {
    logic run_cmd;
    logic fwd_req;
    logic rev_req;
    logic freq_dec;
    logic drive_running;
    logic trip;
    logic temp_high;
    logic thm_over;
  } dpac_sense_t;

  typedef struct packed {
    logic ramp_down;
    logic output_cut;
    logic fwd_allow;
    logic rev_allow;
    logic ocl_active;
    logic pf_follow_decel;
    logic pf_follow_climit;
    logic pf_time_auto;
  } dpac_ctl_t;
endpackage : dpac_pkg

// >>> core/dpac_retry.sv
`timescale 1ns/1ps
`include "dpac_consts.svh"

module dpac_retry
  import dpac_pkg::*;
#(
  parameter int TICK_CYCLES = `DPAC_CLK_HZ / `DPAC_TICK_S_DIV
) (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       tick,
  input  wire logic       trip,
  input  wire logic       running,
  input  wire logic [3:0] retry_max,
  input  wire logic [7:0] retry_ivl,
  output logic            reset_pulse,
  output logic            in_progress,
  output logic            alarm
);
  typedef enum logic [1:0] {DPAC_R_IDLE, DPAC_R_WAIT, DPAC_R_ALARM} dpac_rstate_t;

  dpac_rstate_t state_q;
  logic [3:0]   tries_q;
  logic [7:0]   ivl_q;
  logic         trip_q;

  wire trip_rise = trip & ~trip_q;
  wire ivl_done  = tick & (ivl_q >= retry_ivl);
  wire tries_out = (tries_q >= retry_max);

  // elaboration-time refusal of a tick period the counter cannot serve
  if (TICK_CYCLES < 1) begin : g_bad_tick
    $error("dpac_retry: TICK_CYCLES must be positive");
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_q     <= DPAC_R_IDLE;
      tries_q     <= 4'h0;
      ivl_q       <= 8'h00;
      trip_q      <= 1'b0;
      reset_pulse <= 1'b0;
      alarm       <= 1'b0;
    end else begin
      trip_q      <= trip;
      reset_pulse <= 1'b0;
      case (state_q)
        DPAC_R_IDLE: begin
          if (running && !trip) tries_q <= 4'h0;
          if (trip_rise) begin
            ivl_q <= 8'h00;
            if (retry_max == 4'h0 || tries_out) begin
              state_q <= DPAC_R_ALARM;
              alarm   <= 1'b1;
            end else begin
              state_q <= DPAC_R_WAIT;
            end
          end
        end
        DPAC_R_WAIT: begin
          if (tick) ivl_q <= ivl_q + 8'h01;
          if (ivl_done) begin
            reset_pulse <= 1'b1;
            tries_q     <= tries_q + 4'h1;
            state_q     <= DPAC_R_IDLE;
          end
        end
        DPAC_R_ALARM: begin
          if (!trip) begin
            state_q <= DPAC_R_IDLE;
            alarm   <= 1'b0;
            tries_q <= 4'h0;
          end
        end
        default: state_q <= DPAC_R_IDLE;
      endcase
    end
  end

  // busy from first trip until drive runs again clean or alarm
  always_ff @(posedge ref_clk) begin
    if (rst) in_progress <= 1'b0;
    else if (state_q == DPAC_R_ALARM) in_progress <= 1'b0;
    else if (state_q == DPAC_R_WAIT) in_progress <= 1'b1;
    else if (running && !trip) in_progress <= 1'b0;
  end
endmodule : dpac_retry

// >>> core/dpac_top.sv
// What this block does
// - retry count zero disables, else 1-10 attempts
// - wait programmed interval before reset attempt
// - too many trips: alarm, stop retrying
// - count three: fourth trip gives alarm
// - busy output high during auto reset
// - fan mode 0 always on, 1 controlled
// - fan off only stopped and cool
// - fan runs at least ten minutes
// - fan status output follows fan in mode 1 only, stays low in mode 0
// - direction limit: none, no reverse, no forward
// - stop mode ramps or cuts output
// - coast mode still ramps on frequency drop
// - overcurrent limiter select, resets enabled
// - restart fall rate: decel, rate, or limit
// - power fail time 0-30 s or auto
// - thermistor mode 1 trips on overheat
// - thermistor mode 2 warns, keeps running
// - thermistor mode 3 trips above level
`timescale 1ns/1ps
`include "dpac_consts.svh"

module dpac_top
  import dpac_pkg::*;
#(
  parameter int TICK_CYCLES     = `DPAC_CLK_HZ / `DPAC_TICK_S_DIV,
  parameter int FAN_HOLD_TICKS  = `DPAC_FAN_HOLD_TICKS
) (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire dpac_pkg::dpac_sense_t sense,
  output dpac_pkg::dpac_ctl_t        ctl,
  output logic             fan_on,
  output logic             fan_running_out,
  output logic             auto_reset_active_out,
  output logic             alarm_out,
  output logic             motor_overheat_trip,
  output logic             motor_overtemp_warning_out,
  output logic             retry_reset_pulse,
  output logic             irq
);
  import dpac_pkg::*;

  // elaboration-time refusal of counts the timers cannot serve
  if (TICK_CYCLES < 1) begin : g_bad_tick
    $error("dpac_top: TICK_CYCLES must be positive");
  end
  if (FAN_HOLD_TICKS < 1) begin : g_bad_hold
    $error("dpac_top: FAN_HOLD_TICKS must be positive");
  end

  function automatic logic [7:0] clamp_ivl(input logic [7:0] v);
    if (v < `DPAC_IVL_MIN) return `DPAC_IVL_MIN;
    if (v > `DPAC_IVL_MAX) return `DPAC_IVL_MAX;
    return v;
  endfunction : clamp_ivl

  function automatic logic [15:0] clamp16(input logic [15:0] v, input logic [15:0] mx);
    if (v == `DPAC_PF_AUTO) return v;
    return (v > mx) ? mx : v;
  endfunction : clamp16

  // ---- ahb-lite slave ----
  logic [31:0] ctrl_q, retry_q, pfail_q, irq_en_q;
  logic [`DPAC_IRQ_W-1:0] irq_sts_q;
  logic        wr_pend_q;
  logic [7:0]  wr_addr_q;

  wire        addr_ph  = hsel & hready & htrans[1];
  wire        rd_req   = addr_ph & ~hwrite;
  wire        wr_req   = addr_ph & hwrite;
  wire [7:0]  rd_addr  = haddr[7:0];

  wire wr_ctrl  = wr_pend_q && (wr_addr_q == `DPAC_OFF_CTRL);
  wire wr_retry = wr_pend_q && (wr_addr_q == `DPAC_OFF_RETRY);
  wire wr_pfail = wr_pend_q && (wr_addr_q == `DPAC_OFF_PFAIL);
  wire wr_ien   = wr_pend_q && (wr_addr_q == `DPAC_OFF_IRQ_EN);
  wire wr_iclr  = wr_pend_q && (wr_addr_q == `DPAC_OFF_IRQ_CLR);

  // ---- live configuration ----
  dpac_cfg_t cfg;
  assign cfg.fan_ctrl_en = ctrl_q[`DPAC_CTRL_FAN_BIT];
  assign cfg.dir_limit   = dpac_dir_t'(ctrl_q[`DPAC_CTRL_DIR_LSB +: 2]);
  assign cfg.coast_stop  = ctrl_q[`DPAC_CTRL_STOP_BIT];
  assign cfg.ocl_en      = ctrl_q[`DPAC_CTRL_OCL_BIT];
  assign cfg.thm_mode    = dpac_thm_t'(ctrl_q[`DPAC_CTRL_THM_LSB +: 2]);
  assign cfg.retry_cnt   = retry_q[`DPAC_RETRY_CNT_LSB +: 4];
  assign cfg.retry_ivl   = retry_q[`DPAC_RETRY_IVL_LSB +: 8];
  assign cfg.pf_rate     = pfail_q[`DPAC_PF_RATE_LSB +: 16];
  assign cfg.pf_time     = pfail_q[`DPAC_PF_TIME_LSB +: 16];

  wire [3:0] wr_cnt   = hwdata[`DPAC_RETRY_CNT_LSB +: 4];
  wire [3:0] cnt_safe = (wr_cnt > `DPAC_RETRY_MAX) ? `DPAC_RETRY_MAX : wr_cnt;
  wire [7:0] ivl_safe = clamp_ivl(hwdata[`DPAC_RETRY_IVL_LSB +: 8]);
  wire [15:0] rate_safe = clamp16(hwdata[`DPAC_PF_RATE_LSB +: 16], `DPAC_PF_RATE_MAX);
  wire [15:0] time_safe = clamp16(hwdata[`DPAC_PF_TIME_LSB +: 16], `DPAC_PF_TIME_MAX);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else begin
      wr_pend_q <= wr_req;
      wr_addr_q <= haddr[7:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl_q   <= `DPAC_CTRL_RESET;
      retry_q  <= `DPAC_RETRY_RESET;
      pfail_q  <= `DPAC_PFAIL_RESET;
      irq_en_q <= 32'h0000_0000;
    end else begin
      if (wr_ctrl) ctrl_q <= {25'h0, hwdata[6:0]};
      if (wr_retry) retry_q <= {16'h0, ivl_safe, 4'h0, cnt_safe};
      if (wr_pfail) pfail_q <= {time_safe, rate_safe};
      if (wr_ien) irq_en_q <= {28'h0, hwdata[`DPAC_IRQ_W-1:0]};
    end
  end

  // ---- 0.1 s tick ----
  logic [31:0] tick_cnt_q;
  logic        tick_q;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tick_cnt_q <= 32'h0;
      tick_q     <= 1'b0;
    end else begin
      tick_q     <= (tick_cnt_q == 32'(TICK_CYCLES - 1));
      tick_cnt_q <= (tick_cnt_q == 32'(TICK_CYCLES - 1)) ? 32'h0 : tick_cnt_q + 32'h1;
    end
  end

  // ---- thermistor ----
  wire thm_trip_d = sense.thm_over &&
                    (cfg.thm_mode == DPAC_THM_TRIP || cfg.thm_mode == DPAC_THM_NTC);
  wire thm_warn_d = sense.thm_over && (cfg.thm_mode == DPAC_THM_WARN);

  // ---- auto retry ----
  wire retry_pulse, retry_busy, retry_alarm;
  dpac_retry #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_retry (
    .ref_clk     (ref_clk),
    .rst         (rst),
    .tick        (tick_q),
    .trip        (sense.trip | motor_overheat_trip),
    .running     (sense.drive_running),
    .retry_max   (cfg.retry_cnt),
    .retry_ivl   (cfg.retry_ivl),
    .reset_pulse (retry_pulse),
    .in_progress (retry_busy),
    .alarm       (retry_alarm)
  );

  // ---- cooling fan ----
  logic [31:0] fan_hold_q;
  logic        fan_q;
  wire fan_may_stop = cfg.fan_ctrl_en && !sense.drive_running && !sense.temp_high;
  wire fan_hold_done = (fan_hold_q == 32'h0);
  wire fan_d = !cfg.fan_ctrl_en ? 1'b1 :
               (fan_q && !(fan_may_stop && fan_hold_done)) ||
               (!fan_q && !fan_may_stop);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      fan_q      <= 1'b1;
      fan_hold_q <= 32'(FAN_HOLD_TICKS);
    end else begin
      fan_q <= fan_d;
      if (!fan_q && fan_d) fan_hold_q <= 32'(FAN_HOLD_TICKS);
      else if (tick_q && !fan_hold_done) fan_hold_q <= fan_hold_q - 32'h1;
    end
  end

  // ---- drive control outputs ----
  dpac_ctl_t ctl_d;
  assign ctl_d.ramp_down  = (!sense.run_cmd && !cfg.coast_stop) ||
                            (sense.run_cmd && sense.freq_dec);
  assign ctl_d.output_cut = !sense.run_cmd && cfg.coast_stop;
  assign ctl_d.fwd_allow  = sense.fwd_req && (cfg.dir_limit != DPAC_DIR_NO_FWD);
  assign ctl_d.rev_allow  = sense.rev_req && (cfg.dir_limit != DPAC_DIR_NO_REV);
  assign ctl_d.ocl_active = cfg.ocl_en;
  assign ctl_d.pf_follow_decel  = (cfg.pf_rate == 16'h0000);
  assign ctl_d.pf_follow_climit = (cfg.pf_rate == `DPAC_PF_AUTO);
  assign ctl_d.pf_time_auto     = (cfg.pf_time == `DPAC_PF_AUTO);

  // ---- interrupts ----
  wire [`DPAC_IRQ_W-1:0] irq_ev = {thm_warn_d & ~motor_overtemp_warning_out,
                                   retry_pulse,
                                   retry_alarm & ~alarm_out,
                                   sense.trip};
  wire [`DPAC_IRQ_W-1:0] irq_clr = wr_iclr ? hwdata[`DPAC_IRQ_W-1:0] : '0;

  always_ff @(posedge ref_clk) begin
    if (rst) irq_sts_q <= '0;
    else irq_sts_q <= (irq_sts_q & ~irq_clr) | irq_ev;
  end

  // ---- read mux ----
  wire [31:0] status_w = {24'h0, fan_q, retry_busy, retry_alarm, thm_trip_d,
                          thm_warn_d, sense.drive_running, sense.trip, sense.temp_high};
  wire [31:0] rd_mux =
      (rd_addr == `DPAC_OFF_CTRL)    ? ctrl_q :
      (rd_addr == `DPAC_OFF_RETRY)   ? retry_q :
      (rd_addr == `DPAC_OFF_PFAIL)   ? pfail_q :
      (rd_addr == `DPAC_OFF_STATUS)  ? status_w :
      (rd_addr == `DPAC_OFF_IRQ_STS) ? {28'h0, irq_sts_q} :
      (rd_addr == `DPAC_OFF_IRQ_EN)  ? irq_en_q : 32'h0;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      hrdata    <= 32'h0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (rd_req) hrdata <= rd_mux;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctl                        <= '0;
      fan_on                     <= 1'b1;
      fan_running_out            <= 1'b0;
      auto_reset_active_out      <= 1'b0;
      alarm_out                  <= 1'b0;
      motor_overheat_trip        <= 1'b0;
      motor_overtemp_warning_out <= 1'b0;
      retry_reset_pulse          <= 1'b0;
      irq                        <= 1'b0;
    end else begin
      ctl                        <= ctl_d;
      fan_on                     <= fan_d;
      fan_running_out            <= cfg.fan_ctrl_en & fan_d;
      auto_reset_active_out      <= retry_busy;
      alarm_out                  <= retry_alarm;
      motor_overheat_trip        <= thm_trip_d;
      motor_overtemp_warning_out <= thm_warn_d;
      retry_reset_pulse          <= retry_pulse;
      irq                        <= |(((irq_sts_q & ~irq_clr) | irq_ev) & irq_en_q[`DPAC_IRQ_W-1:0]);
    end
  end
endmodule : dpac_top

// >>> dv/dpac_checker.sv
`timescale 1ns/1ps
module dpac_checker #(
  parameter int TICK_CYCLES    = 10,
  parameter int FAN_HOLD_TICKS = 4
) (
  input wire logic                  ref_clk,
  input wire logic                  rst,
  input wire dpac_pkg::dpac_sense_t sense,
  input wire dpac_pkg::dpac_ctl_t   ctl,
  input wire logic                  fan_on,
  input wire logic                  fan_running_out,
  input wire logic                  auto_reset_active_out,
  input wire logic                  alarm_out,
  input wire logic                  motor_overheat_trip,
  input wire logic                  motor_overtemp_warning_out,
  input wire logic                  retry_reset_pulse
);
  import dpac_pkg::*;
  localparam int IVL_LOW  = 4 * TICK_CYCLES;
  localparam int HOLD_LOW = (FAN_HOLD_TICKS - 1) * TICK_CYCLES;
  int unsigned fan_cnt_q;
  int unsigned trip_cnt_q;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // cycles the fan has run, and cycles the trip has stood
  always_ff @(posedge ref_clk) begin
    if (rst || !fan_on) fan_cnt_q <= 0;
    else if (fan_cnt_q < 100000) fan_cnt_q <= fan_cnt_q + 1;
    if (rst || !(sense.trip || motor_overheat_trip)) trip_cnt_q <= 0;
    else if (trip_cnt_q < 100000) trip_cnt_q <= trip_cnt_q + 1;
  end
  property p_busy; retry_reset_pulse |-> auto_reset_active_out; endproperty
  a_busy: assert property (p_busy) else $error("reset pulse without busy");
  property p_alarm_stop; alarm_out |-> !retry_reset_pulse; endproperty
  a_alarm_stop: assert property (p_alarm_stop) else $error("retry during alarm");
  property p_ivl; retry_reset_pulse |-> trip_cnt_q >= IVL_LOW; endproperty
  a_ivl: assert property (p_ivl) else $error("retry too early");
  property p_fan_off;
    $fell(fan_on) |-> !$past(sense.drive_running) && !$past(sense.temp_high);
  endproperty
  a_fan_off: assert property (p_fan_off) else $error("fan off while busy or hot");
  property p_fan_hold; $fell(fan_on) |-> fan_cnt_q >= HOLD_LOW; endproperty
  a_fan_hold: assert property (p_fan_hold) else $error("fan hold too short");
  property p_fan_sts; fan_running_out |-> fan_on || $past(fan_on); endproperty
  a_fan_sts: assert property (p_fan_sts) else $error("fan status without fan");
  property p_thm_trip; motor_overheat_trip |-> $past(sense.thm_over); endproperty
  a_thm_trip: assert property (p_thm_trip) else $error("overheat trip unprompted");
  property p_thm_warn;
    motor_overtemp_warning_out |-> $past(sense.thm_over) && !motor_overheat_trip;
  endproperty
  a_thm_warn: assert property (p_thm_warn) else $error("bad overheat warning");
  property p_stop_excl; !(ctl.ramp_down && ctl.output_cut); endproperty
  a_stop_excl: assert property (p_stop_excl) else $error("ramp and cut together");
  property p_cut_cause; ctl.output_cut |-> !$past(sense.run_cmd); endproperty
  a_cut_cause: assert property (p_cut_cause) else $error("cut while run held");
  property p_pf_excl; !(ctl.pf_follow_decel && ctl.pf_follow_climit); endproperty
  a_pf_excl: assert property (p_pf_excl) else $error("two fall rate modes");
  c_retry: cover property (retry_reset_pulse);
  c_alarm: cover property ($rose(alarm_out));
  c_fan_off: cover property ($fell(fan_on));
endmodule : dpac_checker

// >>> dv/dpac_plant.sv
`timescale 1ns/1ps
module dpac_plant (
  input  wire logic                  ref_clk,
  input  wire logic                  rst,
  input  wire dpac_pkg::dpac_sense_t req,
  input  wire logic                  fault_clr,
  input  wire logic                  retry_reset_pulse,
  output dpac_pkg::dpac_sense_t      sense
);
  import dpac_pkg::*;
  logic trip_q;
  // a trip latches; only rst, a reset attempt or an operator clear drops it
  always_ff @(posedge ref_clk) begin
    if (rst || retry_reset_pulse || fault_clr) trip_q <= 1'b0;
    else if (req.trip) trip_q <= 1'b1;
  end
  always_comb begin
    sense = req;
    sense.trip = trip_q;
    sense.drive_running = req.drive_running && !trip_q;
  end
endmodule : dpac_plant

// >>> dv/test_drive_protection_aux_control.sv
`timescale 1ns/1ps
module test_drive_protection_aux_control;
  import dpac_pkg::*;
  logic        ref_clk, rst, hsel, hwrite, hreadyout, hresp, fault_clr;
  logic [31:0] haddr, hwdata, hrdata, v;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  dpac_sense_t req, sense;
  dpac_ctl_t   ctl;
  logic        fan_on, fan_running_out, auto_reset_active_out, alarm_out;
  logic        motor_overheat_trip, motor_overtemp_warning_out, retry_reset_pulse, irq;
  int          err_count, num_checks;
  dpac_top #(.TICK_CYCLES(10), .FAN_HOLD_TICKS(4)) dut_u (
    .ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sense(sense), .ctl(ctl),
    .fan_on(fan_on), .fan_running_out(fan_running_out), .alarm_out(alarm_out),
    .auto_reset_active_out(auto_reset_active_out), .motor_overheat_trip(motor_overheat_trip),
    .motor_overtemp_warning_out(motor_overtemp_warning_out),
    .retry_reset_pulse(retry_reset_pulse), .irq(irq));
  dpac_plant plant_u (.ref_clk(ref_clk), .rst(rst), .req(req), .fault_clr(fault_clr),
    .retry_reset_pulse(retry_reset_pulse), .sense(sense));
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  task automatic finish_test;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : finish_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : chk
  task automatic chk1(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask : chk1
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : cyc
  task automatic rdy;
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin
      err_count++;
      finish_test();
    end
  endtask : rdy
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    hwrite <= w;
    htrans <= 2'h2;
    rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
    r = hrdata;
  endtask : ahb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    ahb(1'b1, a, d, x);
  endtask : wr
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0, v);
    chk(v, e);
  endtask : rchk
  task automatic wait_ev(output int n);
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (retry_reset_pulse !== 1'b1 && alarm_out !== 1'b1 && n < 300);
    if (n >= 300) begin
      err_count++;
      finish_test();
    end
  endtask : wait_ev
  task automatic wait_fan(input logic lvl);
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (fan_on !== lvl && n < 300);
    if (n >= 300) begin
      err_count++;
      finish_test();
    end
  endtask : wait_fan
  task automatic fault;
    req.trip <= 1'b1;
    @(posedge ref_clk);
    req.trip <= 1'b0;
  endtask : fault
  task automatic t_regs;
    rchk(8'h00, 32'h0000_0010);
    rchk(8'h04, 32'h0000_3200);
    rchk(8'h08, 32'h03E7_03E7);
    rchk(8'h1C, 32'h0000_0000);
    chk1(hresp, 1'b0);
    chk1(hreadyout, 1'b1);
    chk1(ctl.ocl_active, 1'b1);
    chk1(ctl.pf_follow_climit, 1'b1);
    chk1(ctl.pf_time_auto, 1'b1);
    wr(8'h04, 32'h0000_000F);
    rchk(8'h04, 32'h0000_050A);
    wr(8'h08, 32'h012D_0000);
    rchk(8'h08, 32'h012C_0000);
    cyc(3);
    chk1(ctl.pf_follow_decel, 1'b1);
    chk1(ctl.pf_time_auto, 1'b0);
    wr(8'h08, 32'h03E7_2711);
    rchk(8'h08, 32'h03E7_2710);
    cyc(3);
    chk1(ctl.pf_follow_decel, 1'b0);
    chk1(ctl.pf_follow_climit, 1'b0);
    chk1(ctl.pf_time_auto, 1'b1);
    wr(8'h00, 32'h0);
    cyc(3);
    chk1(ctl.ocl_active, 1'b0);
  endtask : t_regs
  task automatic t_thm;
    wr(8'h04, 32'h0500);
    for (int m = 0; m < 4; m++) begin
      wr(8'h00, 32'h10 | 32'(m << 5));
      req.thm_over <= 1'b1;
      cyc(5);
      chk1(motor_overheat_trip, m[0]);
      chk1(motor_overtemp_warning_out, m == 2);
      chk1(alarm_out, m[0]);
      req.thm_over <= 1'b0;
      cyc(5);
    end
  endtask : t_thm
  task automatic t_dir;
    req.fwd_req <= 1'b1;
    req.rev_req <= 1'b1;
    for (int d = 0; d < 3; d++) begin
      wr(8'h00, 32'h10 | 32'(d << 1));
      cyc(3);
      chk1(ctl.fwd_allow, d != 2);
      chk1(ctl.rev_allow, d != 1);
    end
  endtask : t_dir
  task automatic t_stop;
    for (int c = 0; c < 2; c++) begin
      wr(8'h00, 32'h10 | 32'(c << 3));
      req.run_cmd <= 1'b1;
      req.drive_running <= 1'b1;
      cyc(3);
      req.run_cmd <= 1'b0;
      cyc(3);
      chk1(ctl.ramp_down, c == 0);
      chk1(ctl.output_cut, c == 1);
    end
    req.run_cmd <= 1'b1;
    req.freq_dec <= 1'b1;
    cyc(3);
    chk1(ctl.ramp_down, 1'b1);
    chk1(ctl.output_cut, 1'b0);
    req <= '0;
  endtask : t_stop
  task automatic t_retry;
    int n;
    wr(8'h14, 32'h4);
    wr(8'h18, 32'hF);
    wr(8'h04, 32'h0503);
    for (int i = 0; i < 4; i++) begin
      fault();
      wait_ev(n);
      chk1(retry_reset_pulse, i < 3);
      if (i < 3) begin
        chk1(n >= 38, 1'b1);
        chk1(auto_reset_active_out, 1'b1);
      end
    end
    cyc(2);
    chk1(auto_reset_active_out, 1'b0);
    rchk(8'h10, 32'h0000_0007);
    rchk(8'h0C, 32'h0000_00A2);
    chk1(irq, 1'b1);
    wr(8'h14, 32'h0);
    cyc(3);
    chk1(irq, 1'b0);
    wr(8'h14, 32'h4);
    wr(8'h18, 32'h4);
    cyc(3);
    chk1(irq, 1'b0);
    fault_clr <= 1'b1;
    cyc(1);
    fault_clr <= 1'b0;
    cyc(3);
    chk1(alarm_out, 1'b0);
    wr(8'h04, 32'h0501);
    for (int i = 0; i < 2; i++) begin
      fault();
      wait_ev(n);
      chk1(retry_reset_pulse, 1'b1);
      req.run_cmd <= 1'b1;
      req.drive_running <= 1'b1;
      cyc(6);
    end
    chk1(auto_reset_active_out, 1'b0);
    req <= '0;
  endtask : t_retry
  task automatic t_fan;
    wr(8'h00, 32'h11);
    wait_fan(1'b0);
    cyc(2);
    chk1(fan_running_out, 1'b0);
    req.temp_high <= 1'b1;
    wait_fan(1'b1);
    req.temp_high <= 1'b0;
    cyc(20);
    chk1(fan_on, 1'b1);
    chk1(fan_running_out, 1'b1);
    wait_fan(1'b0);
    req.drive_running <= 1'b1;
    req.temp_high <= 1'b1;
    wait_fan(1'b1);
    req.temp_high <= 1'b0;
    cyc(100);
    chk1(fan_on, 1'b1);
    wr(8'h00, 32'h10);
    req <= '0;
    cyc(100);
    chk1(fan_on, 1'b1);
    chk1(fan_running_out, 1'b0);
  endtask : t_fan
  initial begin
    rst <= 1'b1;
    hsel <= 1'b0;
    haddr <= 32'h0;
    htrans <= 2'h0;
    hwrite <= 1'b0;
    hsize <= 3'h2;
    hwdata <= 32'h0;
    req <= '0;
    fault_clr <= 1'b0;
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    t_regs();
    t_thm();
    t_dir();
    t_stop();
    t_retry();
    t_fan();
    finish_test();
  end
endmodule : test_drive_protection_aux_control
bind dpac_top dpac_checker #(.TICK_CYCLES(TICK_CYCLES), .FAN_HOLD_TICKS(FAN_HOLD_TICKS)) u_chk (
  .ref_clk(ref_clk), .rst(rst), .sense(sense), .ctl(ctl), .fan_on(fan_on),
  .fan_running_out(fan_running_out), .auto_reset_active_out(auto_reset_active_out),
  .alarm_out(alarm_out), .motor_overheat_trip(motor_overheat_trip),
  .motor_overtemp_warning_out(motor_overtemp_warning_out),
  .retry_reset_pulse(retry_reset_pulse));
